// File: design/sec_ctrl.sv
// Serial EEPROM command controller with AHB-Lite register slave.
// Assumes one AHB-Lite master, word transfers, an external 3-wire EEPROM.
// Contract
// - Writing busy one runs the command; busy stays set until done.
// - Busy reads high after reset until the power-up load finishes.
// - Command field codes 000..111 as listed; resets to 000.
// - Read puts the addressed byte into the data register.
// - Write-disable sends the lock sequence.
// - Write-enable unlocks erase and write; software issues it first.
// - Write-location stores the data byte at the address.
// - Write-all stores the data byte everywhere.
// - Erase-location erases the addressed byte.
// - Erase-all starts a bulk erase.
// - Reload fails unless the first byte is A5h.
// - A failed reload changes no loaded contents.
// - No response in 30 ms: abandon, go idle, set timeout flag.
// - Write without EEPROM keeps busy until timeout, then clears.
// - Input held high: no timeout, busy clears when sequence ends.
// - Input low: only erase and write commands may time out.
// - Load-done sets after good load; software clears by writing one.
// - Nine-bit byte address, reset zero, read and write.
`timescale 1ns/1ps
module sec_ctrl #(
   parameter int TIMEOUT_CYCLES = sec_pkg::TIMEOUT_CYC,
   parameter int SCK_HALF       = sec_pkg::SCK_HALF_CYC,
   parameter int CS_GAP         = sec_pkg::CS_GAP_CYC,
   parameter int RELOAD_BYTES   = sec_pkg::RELOAD_BYTES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             sm_select,
   output logic             sm_clock,
   output logic             sm_data_out,
   input  wire logic        serial_mem_data_in,
   output logic             cfg_load_valid,
   output logic [8:0]       cfg_load_index,
   output logic [7:0]       cfg_load_byte
);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam int AW = sec_pkg::AW;
   localparam int DW = sec_pkg::DW;

   typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_GAP, ST_POLL, ST_NEXT} sec_state_t;

   sec_state_t             state, next_state;
   logic                   busy, next_busy;
   logic [2:0]             op, next_op;
   logic [AW-1:0]          addr, next_addr;
   logic                   tmo, next_tmo;
   logic                   loaded, next_loaded;
   logic                   pu_load, next_pu_load;
   logic [2:0]             run_op;
   logic [DW-1:0]          buffer, next_buffer;
   logic                   next_cs;
   logic [TW-1:0]          cnt, next_cnt;
   logic [AW-1:0]          rl_idx, next_rl_idx;
   logic                   sh_start, next_sh_start;
   logic [sec_pkg::NW-1:0] sh_nbits, next_sh_nbits;
   logic [sec_pkg::FW-1:0] sh_frame, next_sh_frame;
   logic                   next_cfg_valid;
   logic [AW-1:0]          next_cfg_index;
   logic [DW-1:0]          next_cfg_byte;
   logic                   sh_done;
   logic [7:0]             sh_rx;
   logic                   din_s;
   logic                   wr_pend;
   logic [11:0]            wr_addr;
   logic                   fin;
   logic                   wr_cmd, wr_dat;
   logic                   ap_valid;
   logic [31:0]            rd_mux;

   // Pin input synchroniser
   sec_sync #(
      .WIDTH (1)
   ) u_sync (
      .clk  (hclk),
      .rstn (hresetn),
      .ce   (ce),
      .din  (serial_mem_data_in),
      .dout (din_s)
   );

   // Serial frame engine
   sec_shifter #(
      .HALF (SCK_HALF),
      .FW   (sec_pkg::FW),
      .NW   (sec_pkg::NW)
   ) u_shift (
      .clk   (hclk),
      .rstn  (hresetn),
      .ce    (ce),
      .start (sh_start),
      .nbits (sh_nbits),
      .frame (sh_frame),
      .din   (din_s),
      .sck   (sm_clock),
      .dout  (sm_data_out),
      .done  (sh_done),
      .rx    (sh_rx)
   );

   // Frame for each command, left aligned
   function automatic logic [sec_pkg::FW-1:0] frame_of(
      input logic [2:0]    c,
      input logic [AW-1:0] a,
      input logic [DW-1:0] d
   );
      logic [sec_pkg::FW-1:0] f;
      f = '0;
      case (c)
         sec_pkg::OP_LOCK:   f = {1'b1, sec_pkg::MW_EXT, sec_pkg::EXT_LOCK, 16'h0};
         sec_pkg::OP_UNLOCK: f = {1'b1, sec_pkg::MW_EXT, sec_pkg::EXT_UNLK, 16'h0};
         sec_pkg::OP_WRITE:  f = {1'b1, sec_pkg::MW_WRITE, a, d, 1'b0};
         sec_pkg::OP_WRALL:  f = {1'b1, sec_pkg::MW_EXT, sec_pkg::EXT_WRALL, 7'h0, d, 1'b0};
         sec_pkg::OP_ERASE:  f = {1'b1, sec_pkg::MW_ERASE, a, 9'h0};
         sec_pkg::OP_ERALL:  f = {1'b1, sec_pkg::MW_EXT, sec_pkg::EXT_ERALL, 16'h0};
         default:            f = {1'b1, sec_pkg::MW_READ, a, 9'h0};
      endcase
      return f;
   endfunction

   // Bits to clock for each command
   function automatic logic [sec_pkg::NW-1:0] nbits_of(input logic [2:0] c);
      case (c)
         sec_pkg::OP_WRITE, sec_pkg::OP_WRALL: return sec_pkg::NB_DATA;
         sec_pkg::OP_READ, sec_pkg::OP_RELOAD: return sec_pkg::NB_READ;
         default:                              return sec_pkg::NB_SHORT;
      endcase
   endfunction

   // Commands that wait for the ready answer
   function automatic logic needs_poll(input logic [2:0] c);
      return c == sec_pkg::OP_WRITE || c == sec_pkg::OP_WRALL ||
             c == sec_pkg::OP_ERASE || c == sec_pkg::OP_ERALL;
   endfunction

   // Bus address phase decode and read mux
   assign ap_valid = hsel && htrans[1] && hready;
   assign wr_cmd   = wr_pend && wr_addr == sec_pkg::CMD_OFF;
   assign wr_dat   = wr_pend && wr_addr == sec_pkg::DATA_OFF;

   // Power-up reload runs while pu_load is set, until the first sequence finishes
   assign run_op = pu_load ? sec_pkg::OP_RELOAD : op;

   always_comb
   begin
      rd_mux = '0;
      if (haddr[11:0] == sec_pkg::CMD_OFF)
      begin
         rd_mux[sec_pkg::BUSY_BIT]                = busy;
         rd_mux[sec_pkg::OP_HI:sec_pkg::OP_LO]    = op;
         rd_mux[sec_pkg::TMO_BIT]                 = tmo;
         rd_mux[sec_pkg::LOAD_BIT]                = loaded;
         rd_mux[AW-1:0]                           = addr;
      end
      else if (haddr[11:0] == sec_pkg::DATA_OFF)
         rd_mux[DW-1:0] = buffer;
   end

   // Bus slave registers: zero wait, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend   <= 1'b0;
         wr_addr   <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else if (ce)
      begin
         wr_pend   <= ap_valid && hwrite;
         wr_addr   <= haddr[11:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (ap_valid && !hwrite)
            hrdata <= rd_mux;
      end
   end

   // Command sequencer and software fields
   always_comb
   begin
      next_state     = state;
      next_busy      = busy;
      next_op        = op;
      next_addr      = addr;
      next_tmo       = tmo;
      next_loaded    = loaded;
      next_pu_load   = pu_load;
      next_buffer    = buffer;
      next_cs        = sm_select;
      next_cnt       = cnt;
      next_rl_idx    = rl_idx;
      next_sh_start  = 1'b0;
      next_sh_nbits  = sh_nbits;
      next_sh_frame  = sh_frame;
      next_cfg_valid = 1'b0;
      next_cfg_index = cfg_load_index;
      next_cfg_byte  = cfg_load_byte;
      fin            = 1'b0;
      // Software writes; fields locked while busy, except load-done clear
      if (wr_cmd)
      begin
         if (hwdata[sec_pkg::LOAD_BIT])
            next_loaded = 1'b0;
         if (!busy)
         begin
            next_op   = hwdata[sec_pkg::OP_HI:sec_pkg::OP_LO];
            next_addr = hwdata[AW-1:0];
            next_busy = hwdata[sec_pkg::BUSY_BIT];
         end
      end
      if (wr_dat && !busy)
         next_buffer = hwdata[DW-1:0];
      case (state)
         ST_IDLE:
         begin
            if (busy)
            begin
               next_tmo      = 1'b0;
               next_cs       = 1'b1;
               next_sh_start = 1'b1;
               next_sh_nbits = nbits_of(run_op);
               next_sh_frame = frame_of(run_op, (run_op == sec_pkg::OP_RELOAD) ? rl_idx : addr,
                                        buffer);
               next_state    = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (sh_done)
            begin
               next_cs  = 1'b0;
               next_cnt = '0;
               if (needs_poll(run_op))
                  next_state = ST_GAP;
               else if (run_op == sec_pkg::OP_READ)
               begin
                  next_buffer = sh_rx;
                  fin         = 1'b1;
               end
               else if (run_op == sec_pkg::OP_RELOAD)
               begin
                  if (rl_idx == '0 && sh_rx != sec_pkg::SIG_BYTE)
                     fin = 1'b1;
                  else
                  begin
                     if (rl_idx != '0)
                     begin
                        next_cfg_valid = 1'b1;
                        next_cfg_index = rl_idx;
                        next_cfg_byte  = sh_rx;
                     end
                     if (rl_idx == AW'(RELOAD_BYTES - 1))
                     begin
                        next_loaded = 1'b1;
                        fin         = 1'b1;
                     end
                     else
                     begin
                        next_rl_idx = rl_idx + AW'(1);
                        next_state  = ST_NEXT;
                     end
                  end
               end
               else
                  fin = 1'b1;
            end
         end
         ST_GAP, ST_NEXT:
         begin
            // Select low for the least gap
            next_cnt = cnt + TW'(1);
            if (cnt == TW'(CS_GAP - 1))
            begin
               next_cs  = 1'b1;
               next_cnt = '0;
               if (state == ST_NEXT)
               begin
                  next_sh_start = 1'b1;
                  next_sh_frame = frame_of(sec_pkg::OP_READ, rl_idx, buffer);
                  next_state    = ST_SHIFT;
               end
               else
                  next_state = ST_POLL;
            end
         end
         ST_POLL:
         begin
            // Wait for ready with the timeout
            next_cnt = cnt + TW'(1);
            if (din_s)
               fin = 1'b1;
            else if (cnt == TW'(TIMEOUT_CYCLES - 1))
            begin
               next_tmo = 1'b1;
               fin      = 1'b1;
            end
         end
         default:
            next_state = ST_IDLE;
      endcase
      if (fin)
      begin
         next_cs     = 1'b0;
         next_busy   = 1'b0;
         next_rl_idx = '0;
         next_pu_load = 1'b0;
         next_state  = ST_IDLE;
      end
   end

   // Sequencer registers; busy and reload pending out of reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state          <= ST_IDLE;
         busy           <= 1'b1;
         op             <= sec_pkg::OP_READ;
         pu_load        <= 1'b1;
         addr           <= '0;
         tmo            <= 1'b0;
         loaded         <= 1'b0;
         buffer         <= '0;
         sm_select      <= 1'b0;
         cnt            <= '0;
         rl_idx         <= '0;
         sh_start       <= 1'b0;
         sh_nbits       <= '0;
         sh_frame       <= '0;
         cfg_load_valid <= 1'b0;
         cfg_load_index <= '0;
         cfg_load_byte  <= '0;
      end
      else if (ce)
      begin
         state          <= next_state;
         busy           <= next_busy;
         op             <= next_op;
         addr           <= next_addr;
         tmo            <= next_tmo;
         loaded         <= next_loaded;
         pu_load        <= next_pu_load;
         buffer         <= next_buffer;
         sm_select      <= next_cs;
         cnt            <= next_cnt;
         rl_idx         <= next_rl_idx;
         sh_start       <= next_sh_start;
         sh_nbits       <= next_sh_nbits;
         sh_frame       <= next_sh_frame;
         cfg_load_valid <= next_cfg_valid;
         cfg_load_index <= next_cfg_index;
         cfg_load_byte  <= next_cfg_byte;
      end
   end

   // Checks
   logic seen;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         seen <= 1'b0;
      else
         seen <= 1'b1;
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_launch;
      ce && wr_cmd && !busy && hwdata[sec_pkg::BUSY_BIT];
   endsequence
   sequence s_started;
      ##1 busy ##1 (state == ST_SHIFT || !$past(ce));
   endsequence

   a_busy_at_reset: assert property (!seen |-> busy)
      else $error("busy low right after reset");
   a_cmd_launch: assert property (s_launch |-> s_started)
      else $error("command did not start");
   a_busy_held: assert property (state != ST_IDLE |-> busy)
      else $error("busy dropped during operation");
   a_locked_fields: assert property (ce && wr_cmd && busy |=> op == $past(op))
      else $error("command changed while busy");
   a_read_result: assert property (ce && state == ST_SHIFT && sh_done &&
      run_op == sec_pkg::OP_READ |=> buffer == $past(sh_rx) && !busy)
      else $error("read byte not stored");
   a_timeout_flag: assert property (ce && state == ST_POLL && !din_s &&
      cnt == TW'(TIMEOUT_CYCLES - 1) |=> tmo && !busy && state == ST_IDLE)
      else $error("timeout not flagged");
   a_no_short_poll: assert property (ce && state == ST_SHIFT && sh_done &&
      !needs_poll(run_op) && run_op != sec_pkg::OP_RELOAD |=> state == ST_IDLE)
      else $error("short command waited for ready");
   a_reload_fail: assert property (ce && state == ST_SHIFT && sh_done &&
      run_op == sec_pkg::OP_RELOAD && rl_idx == '0 && sh_rx != sec_pkg::SIG_BYTE
      |=> !cfg_load_valid && loaded == $past(loaded))
      else $error("failed reload changed contents");
   a_addr_write: assert property (ce && wr_cmd && !busy
      |=> addr == $past(hwdata[AW-1:0]))
      else $error("address field not written");
endmodule

// File: design/sec_shifter.sv
// Serial frame engine: shifts a frame out MSB first, samples input.
// Assumes select is driven by the caller around start and done.
`timescale 1ns/1ps
module sec_shifter #(
   parameter int HALF = 100,
   parameter int FW   = 21,
   parameter int NW   = 5
) (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic          ce,
   input  wire logic          start,
   input  wire logic [NW-1:0] nbits,
   input  wire logic [FW-1:0] frame,
   input  wire logic          din,
   output logic               sck,
   output logic               dout,
   output logic               done,
   output logic [7:0]         rx
);
   localparam int DVW = $clog2(HALF + 1);
   logic           active, next_active;
   logic [DVW-1:0] div, next_div;
   logic [NW-1:0]  bitcnt, next_bitcnt;
   logic [FW-1:0]  shreg, next_shreg;
   logic           next_sck, next_done;
   logic [7:0]     next_rx;

   assign dout = shreg[FW-1];

   // Bit timing: rise samples, fall shifts
   always_comb
   begin
      next_active = active;
      next_div    = div;
      next_bitcnt = bitcnt;
      next_shreg  = shreg;
      next_sck    = sck;
      next_done   = 1'b0;
      next_rx     = rx;
      if (start)
      begin
         next_active = 1'b1;
         next_shreg  = frame;
         next_bitcnt = nbits;
         next_div    = '0;
         next_sck    = 1'b0;
      end
      else if (active)
      begin
         if (div == DVW'(HALF - 1))
         begin
            next_div = '0;
            if (!sck)
            begin
               next_sck = 1'b1;
               next_rx  = {rx[6:0], din};
            end
            else
            begin
               next_sck   = 1'b0;
               next_shreg = {shreg[FW-2:0], 1'b0};
               if (bitcnt == NW'(1))
               begin
                  next_active = 1'b0;
                  next_done   = 1'b1;
               end
               else
                  next_bitcnt = bitcnt - NW'(1);
            end
         end
         else
            next_div = div + DVW'(1);
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         active <= 1'b0;
         div    <= '0;
         bitcnt <= '0;
         shreg  <= '0;
         sck    <= 1'b0;
         done   <= 1'b0;
         rx     <= '0;
      end
      else if (ce)
      begin
         active <= next_active;
         div    <= next_div;
         bitcnt <= next_bitcnt;
         shreg  <= next_shreg;
         sck    <= next_sck;
         done   <= next_done;
         rx     <= next_rx;
      end
   end
endmodule

// File: design/sec_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the input is asynchronous to hclk.
`timescale 1ns/1ps
module sec_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // Two flops, second only reads first
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= '0;
         dout <= '0;
      end
      else if (ce)
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// File: dv/sec_mem_model.sv
// Behavioural three-wire serial EEPROM of 512 bytes for the bench.
// Assumes select-high frames, bits taken on the rising serial clock.
`timescale 1ns/1ps
module sec_mem_model (
   input  wire logic sel,
   input  wire logic sck,
   input  wire logic di,
   input  wire logic present,
   input  wire logic pull_hi,
   output logic      dq
);
   logic [7:0]  mem [512];
   logic [20:0] sr;
   logic [7:0]  ob;
   logic        we;
   logic        drv;
   logic        bitv;
   logic        prog;
   logic        rd;
   logic        hit;
   int          n;
   // Released line sits at its pull level, busy while programming
   assign dq = !present ? pull_hi : drv ? bitv : (sel && prog) ? 1'b0 : pull_hi;
   // Locked at power-up, signature in byte zero
   initial
   begin
      we = 1'b0;
      drv = 1'b0;
      prog = 1'b0;
      rd = 1'b0;
      n = 0;
      sr = '0;
      foreach (mem[i])
         mem[i] = 8'(i) ^ 8'h5a;
      mem[0] = 8'ha5;
   end
   // Shift command bits in, read data out after the address
   always @(posedge sck)
   begin
      if (sel)
      begin
         sr = {sr[19:0], di};
         n = n + 1;
         if (n == 12)
            rd = (sr[10:9] == 2'h2);
         if (n == 12)
            ob = mem[sr[8:0]];
         if (rd && n >= 13 && n <= 20)
         begin
            bitv <= #1 ob[20-n];
            drv <= #1 1'b1;
         end
      end
   end
   // Act on a finished frame when select falls
   always @(negedge sel)
   begin
      drv = 1'b0;
      hit = 1'b0;
      if (n == 12 && sr[10:7] == 4'h0)
         we = 1'b0;
      if (n == 12 && sr[10:7] == 4'h3)
         we = 1'b1;
      if (n == 12 && sr[10:7] == 4'h2 && we)
      begin
         foreach (mem[i])
            mem[i] = 8'hff;
         hit = 1'b1;
      end
      if (n == 12 && sr[10:9] == 2'h3 && we)
      begin
         mem[sr[8:0]] = 8'hff;
         hit = 1'b1;
      end
      if (n == 20 && sr[18:17] == 2'h1 && we)
      begin
         mem[sr[16:8]] = sr[7:0];
         hit = 1'b1;
      end
      if (n == 20 && sr[18:15] == 4'h1 && we)
      begin
         foreach (mem[i])
            mem[i] = sr[7:0];
         hit = 1'b1;
      end
      if (hit)
      begin
         prog = 1'b1;
         prog <= #200 1'b0;
      end
      n = 0;
      rd = 1'b0;
   end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the serial EEPROM command controller.
// Assumes the EEPROM model on the serial pins and a zero-wait slave.
`timescale 1ns/1ps
module testbench;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, last_rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        sm_select, sm_clock, sm_data_out, serial_mem_data_in;
   logic        cfg_load_valid, present, pull_hi, rd_ph;
   logic [8:0]  cfg_load_index, a;
   logic [7:0]  cfg_load_byte, d;
   logic [63:0] rq[$];
   logic [16:0] lq[$];
   int          n_fail, n_compared;
   sec_ctrl #(.TIMEOUT_CYCLES(200), .SCK_HALF(2), .CS_GAP(2), .RELOAD_BYTES(4)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sm_select(sm_select), .sm_clock(sm_clock), .sm_data_out(sm_data_out),
      .serial_mem_data_in(serial_mem_data_in), .cfg_load_valid(cfg_load_valid),
      .cfg_load_index(cfg_load_index), .cfg_load_byte(cfg_load_byte));
   sec_mem_model u_mem (.sel(sm_select), .sck(sm_clock), .di(sm_data_out),
      .present(present), .pull_hi(pull_hi), .dq(serial_mem_data_in));
   // Clock generator
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic end_sim();
      n_fail += lq.size();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [63:0] em);
      if (em[31:0] != 32'h0)
      begin
         n_compared++;
         if ((got & em[31:0]) !== em[63:32])
         begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got & em[31:0], em[63:32]);
         end
      end
   endtask
   task automatic cmp_load(input logic [16:0] got);
      logic [16:0] e;
      e = (lq.size() > 0) ? lq.pop_front() : ~got;
      n_compared++;
      if (got !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, e);
      end
   endtask
   // One AHB-Lite single transfer; reads note their expectation
   task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] wd, em);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, ad};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      if (!w)
         rq.push_back({em, 32'h0} | {32'h0, wd});
      do @(posedge hclk); while (hreadyout !== 1'b1);
      #1;
   endtask
   task automatic chk(input logic [11:0] ad, input logic [31:0] e);
      ahb(1'b0, ad, 32'hffffffff, e);
   endtask
   task automatic wait_idle();
      repeat (600)
      begin
         ahb(1'b0, 12'h030, 32'h0, 32'h0);
         if (last_rd[31] === 1'b0)
            break;
      end
      cmp_reg(last_rd, {32'h0, 32'h80000000});
   endtask
   task automatic run(input logic [2:0] op, input logic [8:0] ad);
      ahb(1'b1, 12'h030, {1'b1, op, 19'h0, ad}, 32'h0);
      wait_idle();
   endtask
   function automatic logic [31:0] cw(logic [2:0] op, logic t, logic l, logic [8:0] ad);
      return {1'b0, op, 17'h0, t, l, ad};
   endfunction
   // Result watcher: read data phases and reload byte pulses
   always @(posedge hclk)
   begin
      if (rd_ph && hreadyout === 1'b1)
      begin
         last_rd = hrdata;
         cmp_reg(hrdata, rq.pop_front());
         cmp_reg({31'h0, hresp}, {32'h0, 32'h1});
      end
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
      if (cfg_load_valid === 1'b1)
         cmp_load({cfg_load_index, cfg_load_byte});
   end
   // Watchdog
   initial
   begin
      #400000;
      n_fail++;
      end_sim();
   end
   // Main sequence
   initial
   begin
      {hresetn, hsel, htrans, haddr, hwrite, hwdata, rd_ph, n_fail, n_compared} = '0;
      hsize = 3'h2;
      present = 1'b1;
      pull_hi = 1'b1;
      void'($urandom(32'h8213));
      a = 9'($urandom());
      d = 8'($urandom());
      for (int i = 1; i < 4; i++)
         lq.push_back({9'(i), 8'(i) ^ 8'h5a});
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 12'h030, 32'hf0000000, 32'h80000000);
      wait_idle();
      chk(12'h030, cw(3'h0, 1'b0, 1'b1, 9'h0));
      ahb(1'b1, 12'h030, 32'h200, 32'h0);
      chk(12'h030, 32'h0);
      chk(12'h0fc, 32'h0);
      run(3'h2, 9'h0);
      ahb(1'b1, 12'h034, {24'h0, d}, 32'h0);
      run(3'h3, a);
      run(3'h0, a);
      chk(12'h034, {24'h0, d});
      chk(12'h030, cw(3'h0, 1'b0, 1'b0, a));
      run(3'h1, 9'h0);
      ahb(1'b1, 12'h034, {24'h0, ~d}, 32'h0);
      run(3'h3, a);
      run(3'h0, a);
      chk(12'h034, {24'h0, d});
      run(3'h2, 9'h0);
      run(3'h5, a);
      run(3'h0, a);
      chk(12'h034, 32'hff);
      ahb(1'b1, 12'h034, 32'h3c, 32'h0);
      run(3'h4, 9'h0);
      run(3'h0, 9'h1ff);
      chk(12'h034, 32'h3c);
      run(3'h6, 9'h0);
      run(3'h0, a);
      chk(12'h034, 32'hff);
      ahb(1'b1, 12'h034, 32'h3c, 32'h0);
      run(3'h4, 9'h0);
      run(3'h7, 9'h0);
      chk(12'h030, cw(3'h7, 1'b0, 1'b0, 9'h0));
      ahb(1'b1, 12'h034, 32'ha5, 32'h0);
      run(3'h3, 9'h0);
      for (int i = 1; i < 4; i++)
         lq.push_back({9'(i), 8'h3c});
      run(3'h7, 9'h0);
      chk(12'h030, cw(3'h7, 1'b0, 1'b1, 9'h0));
      ahb(1'b1, 12'h030, {4'h8, 19'h0, a}, 32'h0);
      ahb(1'b1, 12'h030, {4'hb, 19'h0, ~a}, 32'h0);
      wait_idle();
      chk(12'h030, cw(3'h0, 1'b0, 1'b1, a));
      present = 1'b0;
      pull_hi = 1'b0;
      run(3'h3, a);
      chk(12'h030, cw(3'h3, 1'b1, 1'b1, a));
      run(3'h0, a);
      chk(12'h030, cw(3'h0, 1'b0, 1'b1, a));
      pull_hi = 1'b1;
      run(3'h6, 9'h0);
      chk(12'h030, cw(3'h6, 1'b0, 1'b1, 9'h0));
      end_sim();
   end
endmodule

// File: include/sec_pkg.sv
// Constants for the serial EEPROM command controller.
// Assumes a 200 MHz hclk and a three-wire serial EEPROM.
package sec_pkg;
   // Register byte offsets and fields
   localparam logic [11:0] CMD_OFF  = 12'h030;
   localparam logic [11:0] DATA_OFF = 12'h034;
   localparam int BUSY_BIT = 31;
   localparam int OP_HI    = 30;
   localparam int OP_LO    = 28;
   localparam int TMO_BIT  = 10;
   localparam int LOAD_BIT = 9;
   localparam int AW       = 9;
   localparam int DW       = 8;
   // Command field codes
   localparam logic [2:0] OP_READ   = 3'h0;
   localparam logic [2:0] OP_LOCK   = 3'h1;
   localparam logic [2:0] OP_UNLOCK = 3'h2;
   localparam logic [2:0] OP_WRITE  = 3'h3;
   localparam logic [2:0] OP_WRALL  = 3'h4;
   localparam logic [2:0] OP_ERASE  = 3'h5;
   localparam logic [2:0] OP_ERALL  = 3'h6;
   localparam logic [2:0] OP_RELOAD = 3'h7;
   // Serial opcodes and extended sub-codes
   localparam logic [1:0] MW_EXT    = 2'h0;
   localparam logic [1:0] MW_WRITE  = 2'h1;
   localparam logic [1:0] MW_READ   = 2'h2;
   localparam logic [1:0] MW_ERASE  = 2'h3;
   localparam logic [1:0] EXT_LOCK  = 2'h0;
   localparam logic [1:0] EXT_WRALL = 2'h1;
   localparam logic [1:0] EXT_ERALL = 2'h2;
   localparam logic [1:0] EXT_UNLK  = 2'h3;
   localparam logic [7:0] SIG_BYTE  = 8'ha5;
   // Frame sizes in bits
   localparam int FW = 21;
   localparam int NW = 5;
   localparam logic [4:0] NB_SHORT = 5'h0c;
   localparam logic [4:0] NB_DATA  = 5'h14;
   localparam logic [4:0] NB_READ  = 5'h15;
   // Timing
   localparam int CLK_MHZ     = 200;
   localparam int TIMEOUT_MS  = 30;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int SCK_HALF_NS = 500;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int CS_GAP_NS   = 250;
   localparam int CS_GAP_CYC  = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int RELOAD_BYTES = 16;
endpackage
